//--- design/ssc_regs.sv
// Status, serial clock, rise time and frame monitor registers over APB
// Overview of operation
// - With checksum checking on, bits 15:8 of status show the checksum.
// - Bit 7 shows which own address matched; cleared by STOP, START, disable.
// - Bit 6 set on host header in target role; cleared by STOP, START, disable.
// - Bit 5 set on default device address; cleared by STOP, START, disable.
// - Bit 4 set on general call; cleared by STOP, START, disable.
// - Bit 2 shows transmitting; cleared by STOP, START, disable, lost arbitration.
// - Bit 1 shows bus activity; cleared after STOP.
// - Bit 0 set on generated START; cleared by STOP, disable, lost arbitration.
// - Clock config bit 15 selects standard or fast speed; fast_plus_enable forces fast speed whatever bit 15 holds.
// - Clock config bit 14 selects low/high ratio 2 or 16/9 in fast modes.
// - Standard speed: high and low each last divider clock periods.
// - Fast, duty 0: high divider periods, low twice divider periods.
// - Fast, duty 1: high nine times, low sixteen times divider periods.
// - Rise time register accepts half-word or word accesses.
// - Frame edge flags latch in bits 15 to 12; only written 0 clears.
// - Bits 9 and 8 show receive and transmit frame levels.
// - Bits 7 to 4 enable the four frame edge interrupts.
// - Frame monitor bit 1 enables frame timeout detection.
// - Frame monitor bit 0 enables the frame signal interface.
`timescale 1ns/10ps
module ssc_regs
	import ssc_pkg::*;
#(
	parameter int DIV_W = SSC_CK_DIV_W
) (
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	// Protocol core events and levels
	input  wire logic              interface_enable,
	input  wire logic              checksum_enable,
	input  wire logic [7:0]        checksum_value,
	input  wire logic              start_seen,
	input  wire logic              stop_seen,
	input  wire logic              start_generated,
	input  wire logic              arbitration_lost_flag,
	input  wire logic              addr_matched,
	input  wire logic              addr_matched_second,
	input  wire logic              host_header_det,
	input  wire logic              default_addr_det,
	input  wire logic              general_call_det,
	input  wire logic              role_update,
	input  wire logic              role_is_transmit,
	input  wire logic              fast_plus_enable,
	input  wire logic              clock_run,
	// Frame signal pins
	input  wire logic              rx_frame_pin,
	input  wire logic              tx_frame_pin,
	// Serial clock and configuration outputs
	output logic                   scl_drive_low,
	output logic [SSC_RISE_W-1:0]  rise_limit_field,
	output logic                   frame_timeout_enable,
	output logic                   frame_iface_enable,
	output logic                   irq
);

	// Status flags
	logic             second_addr_match_flag_q;
	logic             host_header_seen_q;
	logic             default_addr_seen_q;
	logic             general_call_seen_q;
	logic             transmitter_role_q;
	logic             bus_busy_flag_q;
	logic             controller_role_q;
	// Configuration
	logic             fast_sel_q;
	logic             duty_select_q;
	logic [DIV_W-1:0] clock_divider_q;
	logic [SSC_RISE_W-1:0] rise_q;
	logic [3:0]       frame_flag_q;
	logic [3:0]       frame_flag_d;
	logic [3:0]       frame_ie_q;
	logic             frame_to_en_q;
	logic             frame_en_q;
	// Frame synchronisers and edge history
	logic [1:0]       rx_sync_q;
	logic [1:0]       tx_sync_q;
	logic             rx_prev_q;
	logic             tx_prev_q;
	// Bus interface
	logic             pready_q;
	logic [31:0]      prdata_q;
	logic             pslverr_q;
	// Serial clock generator
	ssc_ck_state_t    ck_state_q;
	logic [DIV_W+4:0] ck_cnt_q;
	logic             scl_low_q;
	logic             irq_q;

	// Address decode
	wire sel_stat  = paddr == SSC_OFS_STAT2;
	wire sel_ckcfg = paddr == SSC_OFS_CKCFG;
	wire sel_rise  = paddr == SSC_OFS_RISE;
	wire sel_frame = paddr == SSC_OFS_FRAME;
	wire sel_any   = sel_stat | sel_ckcfg | sel_rise | sel_frame;
	wire setup     = psel & ~penable;
	wire commit    = psel & penable & pready_q;
	// Rise register takes only half-word or word writes
	wire rise_bad  = pwrite & sel_rise & (pstrb != 4'hF)
		& (pstrb != 4'h3) & (pstrb != 4'hC);
	wire req_err   = ~sel_any | rise_bad;
	wire wr_ok     = commit & pwrite & ~pslverr_q;
	wire wr_ck     = wr_ok & sel_ckcfg;
	wire wr_rise   = wr_ok & sel_rise & pstrb[0];
	wire wr_frame  = wr_ok & sel_frame;

	// Common clear events
	wire clr_ss    = start_seen | stop_seen | ~interface_enable;
	wire clr_role  = clr_ss | arbitration_lost_flag;
	wire clr_ctrl  = stop_seen | ~interface_enable
		| arbitration_lost_flag;

	// Frame level always visible, edges only watched while the frame interface is on
	wire rx_lvl    = rx_sync_q[1];
	wire tx_lvl    = tx_sync_q[1];
	wire [3:0] frame_edge = {4{frame_en_q}} & {
		rx_lvl & ~rx_prev_q,
		~rx_lvl & rx_prev_q,
		tx_lvl & ~tx_prev_q,
		~tx_lvl & tx_prev_q};

	// Read views
	wire [7:0]  csum_view = checksum_enable ? checksum_value : 8'h00;
	wire [31:0] stat_rd = {16'h0000, csum_view,
		second_addr_match_flag_q, host_header_seen_q,
		default_addr_seen_q, general_call_seen_q, 1'b0,
		transmitter_role_q, bus_busy_flag_q,
		controller_role_q};
	wire [31:0] ck_rd = {16'h0000, fast_sel_q, duty_select_q,
		{(14-DIV_W){1'b0}}, clock_divider_q};
	wire [31:0] rise_rd = {{(32-SSC_RISE_W){1'b0}}, rise_q};
	wire [31:0] frame_rd = {16'h0000, frame_flag_q, 2'b00,
		rx_lvl, tx_lvl, frame_ie_q, 2'b00,
		frame_to_en_q, frame_en_q};
	wire [31:0] rd_mux = sel_stat  ? stat_rd  :
		sel_ckcfg ? ck_rd    :
		sel_rise  ? rise_rd  :
		sel_frame ? frame_rd : 32'h0000_0000;

	// Writing 0 clears a flag, a new edge in the same cycle wins
	always_comb begin
		frame_flag_d = frame_flag_q;
		if (wr_frame & pstrb[1]) begin
			frame_flag_d = frame_flag_q
				& pwdata[SSC_FM_RXR:SSC_FM_TXF];
		end
		frame_flag_d = frame_flag_d | frame_edge;
	end

	// Phase lengths chosen by speed and duty
	wire fast_mode = fast_sel_q | fast_plus_enable;
	wire [4:0] mul_hi = ~fast_mode ? SSC_MUL_STD_HI :
		duty_select_q ? SSC_MUL_D1_HI : SSC_MUL_D0_HI;
	wire [4:0] mul_lo = ~fast_mode ? SSC_MUL_STD_LO :
		duty_select_q ? SSC_MUL_D1_LO : SSC_MUL_D0_LO;
	wire [DIV_W+4:0] len_hi = clock_divider_q * mul_hi;
	wire [DIV_W+4:0] len_lo = clock_divider_q * mul_lo;
	wire ck_go   = clock_run & controller_role_q
		& (clock_divider_q != '0);
	wire [DIV_W+4:0] ck_last_hi = len_hi - 1'b1;
	wire [DIV_W+4:0] ck_last_lo = len_lo - 1'b1;
	wire ck_end_hi = ck_cnt_q == ck_last_hi;
	wire ck_end_lo = ck_cnt_q == ck_last_lo;
	wire [DIV_W+4:0] ck_cnt_inc = ck_cnt_q + 1'b1;
	wire irq_d = |(frame_flag_q & frame_ie_q);

	// APB response
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= setup;
			pslverr_q <= setup & req_err;
			if (setup & ~pwrite) begin
				prdata_q <= rd_mux;
			end
		end
	end

	// Second address flag follows the last match
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			second_addr_match_flag_q <= 1'b0;
		end else if (addr_matched) begin
			second_addr_match_flag_q <= addr_matched_second;
		end else if (clr_ss) begin
			second_addr_match_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			host_header_seen_q <= 1'b0;
		end else if (host_header_det & ~controller_role_q) begin
			host_header_seen_q <= 1'b1;
		end else if (clr_ss) begin
			host_header_seen_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			default_addr_seen_q <= 1'b0;
		end else if (default_addr_det) begin
			default_addr_seen_q <= 1'b1;
		end else if (clr_ss) begin
			default_addr_seen_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			general_call_seen_q <= 1'b0;
		end else if (general_call_det) begin
			general_call_seen_q <= 1'b1;
		end else if (clr_ss) begin
			general_call_seen_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			transmitter_role_q <= 1'b0;
		end else if (role_update) begin
			transmitter_role_q <= role_is_transmit;
		end else if (clr_role) begin
			transmitter_role_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_busy_flag_q <= 1'b0;
		end else if (start_seen) begin
			bus_busy_flag_q <= 1'b1;
		end else if (stop_seen) begin
			bus_busy_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			controller_role_q <= 1'b0;
		end else if (start_generated) begin
			controller_role_q <= 1'b1;
		end else if (clr_ctrl) begin
			controller_role_q <= 1'b0;
		end
	end

	// Clock configuration, byte lanes honoured
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_sel_q      <= SSC_RST_CKCFG[SSC_CK_FAST];
			duty_select_q   <= SSC_RST_CKCFG[SSC_CK_DUTY];
			clock_divider_q <= SSC_RST_CKCFG[DIV_W-1:0];
		end else if (wr_ck) begin
			if (pstrb[1]) begin
				fast_sel_q    <= pwdata[SSC_CK_FAST];
				duty_select_q <= pwdata[SSC_CK_DUTY];
				clock_divider_q[DIV_W-1:8] <= pwdata[DIV_W-1:8];
			end
			if (pstrb[0]) begin
				clock_divider_q[7:0] <= pwdata[7:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rise_q <= SSC_RST_RISE;
		end else if (wr_rise) begin
			rise_q <= pwdata[SSC_RISE_W-1:0];
		end
	end

	// Frame monitor control and flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_flag_q  <= SSC_RST_FRAME[SSC_FM_RXR:SSC_FM_TXF];
			frame_ie_q    <= SSC_RST_FRAME[SSC_FM_IE_LSB+3:SSC_FM_IE_LSB];
			frame_to_en_q <= SSC_RST_FRAME[SSC_FM_TOEN];
			frame_en_q    <= SSC_RST_FRAME[SSC_FM_EN];
		end else begin
			frame_flag_q <= frame_flag_d;
			if (wr_frame & pstrb[0]) begin
				frame_ie_q <= pwdata[SSC_FM_IE_LSB+3:
					SSC_FM_IE_LSB];
				frame_to_en_q <= pwdata[SSC_FM_TOEN];
				frame_en_q    <= pwdata[SSC_FM_EN];
			end
		end
	end

	// Frame pins cross in through two flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_sync_q <= 2'b00;
			tx_sync_q <= 2'b00;
			rx_prev_q <= 1'b0;
			tx_prev_q <= 1'b0;
		end else begin
			rx_sync_q <= {rx_sync_q[0], rx_frame_pin};
			tx_sync_q <= {tx_sync_q[0], tx_frame_pin};
			rx_prev_q <= rx_lvl;
			tx_prev_q <= tx_lvl;
		end
	end

	// Serial clock generator, high phase first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ck_state_q <= SSC_CK_IDLE;
			ck_cnt_q   <= '0;
			scl_low_q  <= 1'b0;
		end else if (!ck_go) begin
			ck_state_q <= SSC_CK_IDLE;
			ck_cnt_q   <= '0;
			scl_low_q  <= 1'b0;
		end else begin
			unique case (ck_state_q)
				SSC_CK_IDLE: begin
					ck_state_q <= SSC_CK_HIGH;
					ck_cnt_q   <= '0;
					scl_low_q  <= 1'b0;
				end
				SSC_CK_HIGH: begin
					if (ck_end_hi) begin
						ck_state_q <= SSC_CK_LOW;
						ck_cnt_q   <= '0;
						scl_low_q  <= 1'b1;
					end else begin
						ck_cnt_q <= ck_cnt_inc;
					end
				end
				SSC_CK_LOW: begin
					if (ck_end_lo) begin
						ck_state_q <= SSC_CK_HIGH;
						ck_cnt_q   <= '0;
						scl_low_q  <= 1'b0;
					end else begin
						ck_cnt_q <= ck_cnt_inc;
					end
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	assign pready               = pready_q;
	assign prdata               = prdata_q;
	assign pslverr              = pslverr_q;
	assign scl_drive_low        = scl_low_q;
	assign rise_limit_field     = rise_q;
	assign frame_timeout_enable = frame_to_en_q;
	assign frame_iface_enable   = frame_en_q;
	assign irq                  = irq_q;

endmodule

//--- design/ssc_pkg.sv
// Shared constants for the serial bus status, clock and frame block
package ssc_pkg;
	// Register byte offsets
	localparam logic [11:0] SSC_OFS_STAT2  = 12'h018;
	localparam logic [11:0] SSC_OFS_CKCFG  = 12'h01C;
	localparam logic [11:0] SSC_OFS_RISE   = 12'h020;
	localparam logic [11:0] SSC_OFS_FRAME  = 12'h080;
	// Reset values
	localparam logic [15:0] SSC_RST_CKCFG  = 16'h0000;
	localparam logic [5:0]  SSC_RST_RISE   = 6'h02;
	localparam logic [15:0] SSC_RST_FRAME  = 16'h0000;
	// Second status register fields
	localparam int SSC_ST_CSUM_LSB  = 8;
	localparam int SSC_ST_DUAL      = 7;
	localparam int SSC_ST_HOST      = 6;
	localparam int SSC_ST_DEFA      = 5;
	localparam int SSC_ST_GCALL     = 4;
	localparam int SSC_ST_XMIT      = 2;
	localparam int SSC_ST_BUSY      = 1;
	localparam int SSC_ST_CTRL      = 0;
	// Clock configuration fields
	localparam int SSC_CK_FAST      = 15;
	localparam int SSC_CK_DUTY      = 14;
	localparam int SSC_CK_DIV_W     = 12;
	// Rise time field width
	localparam int SSC_RISE_W       = 6;
	// Frame monitor fields
	localparam int SSC_FM_RXR       = 15;
	localparam int SSC_FM_RXF       = 14;
	localparam int SSC_FM_TXR       = 13;
	localparam int SSC_FM_TXF       = 12;
	localparam int SSC_FM_RXLVL     = 9;
	localparam int SSC_FM_TXLVL     = 8;
	localparam int SSC_FM_IE_LSB    = 4;
	localparam int SSC_FM_TOEN      = 1;
	localparam int SSC_FM_EN        = 0;
	// Clock phase multipliers
	localparam logic [4:0]  SSC_MUL_STD_HI = 5'd1;
	localparam logic [4:0]  SSC_MUL_STD_LO = 5'd1;
	localparam logic [4:0]  SSC_MUL_D0_HI  = 5'd1;
	localparam logic [4:0]  SSC_MUL_D0_LO  = 5'd2;
	localparam logic [4:0]  SSC_MUL_D1_HI  = 5'd9;
	localparam logic [4:0]  SSC_MUL_D1_LO  = 5'd16;
	// Serial clock generator states
	typedef enum logic [1:0] {SSC_CK_IDLE, SSC_CK_HIGH, SSC_CK_LOW}
		ssc_ck_state_t;
endpackage

//--- test/ssc_peer.sv
// Far-side model: protocol events and frame lines toward the block
`timescale 1ns/10ps
module ssc_peer (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Commands from the bench
	input  wire logic [3:0] ev,
	input  wire logic       go,
	input  wire logic [1:0] lvl,
	// One-hot event pulses, frame lines (1 receive, 0 transmit)
	output logic      [8:0] evp,
	output logic      [1:0] pin
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evp <= '0;
			pin <= '0;
		end else begin
			evp <= go ? 9'h001 << ev : 9'h000;
			pin <= lvl;
		end
	end
endmodule

//--- test/ssc_regs_chk.sv
// Port assertions for the ssc_regs block
`timescale 1ns/10ps
module ssc_regs_chk
	import ssc_pkg::*;
#(
	parameter int DIV_W = SSC_CK_DIV_W
) (
	// Clock, reset and APB
	input wire logic                  pclk,
	input wire logic                  presetn,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire logic [11:0]           paddr,
	input wire logic [31:0]           pwdata,
	input wire logic [31:0]           prdata,
	input wire logic [3:0]            pstrb,
	// Events and outputs
	input wire logic                  stop_seen,
	input wire logic                  fast_plus_enable,
	input wire logic                  clock_run,
	input wire logic                  scl_drive_low,
	input wire logic                  frame_timeout_enable,
	input wire logic                  frame_iface_enable,
	input wire logic [SSC_RISE_W-1:0] rise_limit_field
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic [15:0] ck_q;
	logic [16:0] cnt_q;
	logic        sdl_q, ok_q, lo_q;
	wire         su = psel && !penable;
	wire         acc = psel && penable && pready && pwrite;
	wire         rise_a = paddr == SSC_OFS_RISE;
	wire         frm_a = paddr == SSC_OFS_FRAME;
	wire         mapped = paddr inside {SSC_OFS_STAT2, SSC_OFS_CKCFG,
		SSC_OFS_RISE, SSC_OFS_FRAME};
	wire         strb_ok = pstrb == 4'h3 || pstrb == 4'hC || pstrb == 4'hF;
	wire         chg = scl_drive_low != sdl_q;
	wire         fast = ck_q[SSC_CK_FAST] || fast_plus_enable;
	wire         duty = ck_q[SSC_CK_DUTY];
	wire [16:0]  div = 17'(ck_q[DIV_W-1:0]);
	wire [16:0]  m_lo = 17'(!fast ? SSC_MUL_STD_LO :
		duty ? SSC_MUL_D1_LO : SSC_MUL_D0_LO);
	wire [16:0]  m_hi = 17'(!fast ? SSC_MUL_STD_HI :
		duty ? SSC_MUL_D1_HI : SSC_MUL_D0_HI);
	// Shadow of the clock setting and length of the current SCL phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ck_q <= '0;
			cnt_q <= '0;
			sdl_q <= 1'b0;
			ok_q <= 1'b0;
			lo_q <= 1'b0;
		end else begin
			if (acc && paddr == SSC_OFS_CKCFG)
				ck_q <= pwdata[15:0];
			sdl_q <= scl_drive_low;
			cnt_q <= chg ? 17'h1 : cnt_q + 17'h1;
			ok_q <= (chg || ok_q) && clock_run && !stop_seen;
			lo_q <= (lo_q || scl_drive_low) && clock_run;
		end
	end
	property p_rdy; su |=> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready after setup");
	property p_err; su && !mapped |=> pslverr; endproperty
	a_err: assert property (p_err) else $error("unmapped access accepted");
	property p_rwr; acc && rise_a && strb_ok && pstrb[0] |=>
		rise_limit_field == SSC_RISE_W'($past(pwdata)); endproperty
	a_rwr: assert property (p_rwr) else $error("rise not written");
	property p_rbad; acc && rise_a && !strb_ok |=> $stable(rise_limit_field);
	endproperty
	a_rbad: assert property (p_rbad) else $error("bad strobe wrote");
	property p_rrd; su && !pwrite && rise_a |=>
		prdata == 32'(rise_limit_field); endproperty
	a_rrd: assert property (p_rrd) else $error("rise readback");
	property p_fen; acc && frm_a && pstrb[0] |=>
		{frame_timeout_enable, frame_iface_enable} == 2'($past(pwdata));
	endproperty
	a_fen: assert property (p_fen) else $error("frame ctl");
	property p_lo; $fell(scl_drive_low) && ok_q |-> cnt_q == div * m_lo;
	endproperty
	a_lo: assert property (p_lo) else $error("low time");
	property p_hi; $rose(scl_drive_low) && ok_q && lo_q |->
		cnt_q == div * m_hi; endproperty
	a_hi: assert property (p_hi) else $error("high time");
endmodule

//--- test/ssc_regs_tb.sv
// Self-checking bench for the ssc_regs block
`timescale 1ns/10ps
module ssc_regs_tb;
	import ssc_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd, e;
	logic [3:0]  pstrb = '0, ev = '0;
	logic        pready, pslverr, err, sdl, toen, fen, irq, go = 0;
	logic        ifen = 1, csen = 0, fpe = 0, crun = 0, amsec = 1, rtx = 1;
	logic [7:0]  csv = '0;
	logic [1:0]  lvl = '0, pin;
	logic [8:0]  evp;
	logic [5:0]  rise;
	logic [11:0] d;
	int          n_errors = 0, num_checks = 0, seed = 13375, k, i, j;
	int          sev[7] = '{4, 5, 6, 7, 8, 1, 0};
	int          sbit[7] = '{7, 6, 5, 4, 2, 1, 0};
	int          sclr[7] = '{1, 2, 9, 2, 3, 2, 3};
	logic [11:0] ofs[4] = '{SSC_OFS_STAT2, SSC_OFS_CKCFG, SSC_OFS_RISE,
		SSC_OFS_FRAME};
	always #25 pclk = ~pclk;
	ssc_peer peer (.pclk, .presetn, .ev, .go, .lvl, .evp, .pin);
	ssc_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .pready, .prdata, .pslverr, .interface_enable(ifen),
		.checksum_enable(csen), .checksum_value(csv), .start_seen(evp[1]),
		.stop_seen(evp[2]), .start_generated(evp[0]),
		.arbitration_lost_flag(evp[3]), .addr_matched(evp[4]),
		.addr_matched_second(amsec), .host_header_det(evp[5]),
		.default_addr_det(evp[6]), .general_call_det(evp[7]),
		.role_update(evp[8]), .role_is_transmit(rtx), .fast_plus_enable(fpe),
		.clock_run(crun), .rx_frame_pin(pin[1]), .tx_frame_pin(pin[0]),
		.scl_drive_low(sdl), .rise_limit_field(rise),
		.frame_timeout_enable(toen), .frame_iface_enable(fen), .irq);
	function automatic int mul(int m, bit lo);
		if (m == 0)
			return 1;
		if (m == 1)
			return lo ? 2 : 1;
		return lo ? 16 : 9;
	endfunction
	function automatic logic [31:0] fexp(int n);
		return (32'h1 << (15 - n)) | (n == 0 ? 32'h200 : n == 2 ? 32'h100 : 0);
	endfunction
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] x, logic [31:0] s);
		num_checks++;
		if (s !== x) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic apb(logic w, logic [11:0] a, logic [31:0] dt, logic [3:0] s);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= dt;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		if (i == 20) begin
			n_errors++;
			test_done();
		end
	endtask
	// Counts edges while the SCL drive stays at v, bounded
	task automatic wait_lvl(logic v, output int n);
		for (n = 0; n < 400 && sdl === v; n++)
			@(posedge pclk);
		if (n == 400) begin
			n_errors++;
			test_done();
		end
	endtask
	// Event 9 stands for a one-cycle interface disable
	task automatic pulse(int n);
		@(posedge pclk);
		if (n == 9)
			ifen <= 0;
		else begin
			go <= 1;
			ev <= 4'(n);
		end
		@(posedge pclk);
		go <= 0;
		ifen <= 1;
		repeat (2) @(posedge pclk);
	endtask
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1;
		for (k = 0; k < 4; k++) begin
			apb(0, ofs[k], 0, 4'hF);
			chk("reset_value", k == 2 ? 32'h2 : 32'h0, rd);
		end
		apb(0, 12'h004, 0, 4'hF);
		chk("unmapped_err", 1, err);
		e = $random(seed);
		apb(1, SSC_OFS_RISE, e, 4'h3);
		@(posedge pclk);
		chk("rise_write", e & 32'h3F, 32'(rise));
		apb(1, SSC_OFS_RISE, ~e, 4'h1);
		@(posedge pclk);
		chk("rise_bad_err", 1, err);
		chk("rise_keep", e & 32'h3F, 32'(rise));
		$display("test registers done");
		for (k = 0; k < 3; k++) begin
			d = 12'($random(seed) & 3) + 12'h1;
			e = {16'h0, k == 2, k == 2, 2'b0, d};
			apb(1, SSC_OFS_CKCFG, e, 4'h3);
			apb(0, SSC_OFS_CKCFG, 0, 4'hF);
			chk("clock_cfg", e, rd);
			fpe <= k == 1;
			pulse(0);
			crun <= 1;
			wait_lvl(1'b0, i);
			wait_lvl(1'b1, j);
			chk("scl_low", d * mul(k, 1), j);
			wait_lvl(1'b0, j);
			chk("scl_high", d * mul(k, 0), j);
			crun <= 0;
			pulse(2);
		end
		$display("test clock done");
		for (k = 0; k < 7; k++) begin
			e = 32'h1 << sbit[k];
			pulse(sev[k]);
			apb(0, SSC_OFS_STAT2, 0, 4'hF);
			chk("flag_set", e, rd & e);
			pulse(sclr[k]);
			apb(0, SSC_OFS_STAT2, 0, 4'hF);
			chk("flag_clear", 0, rd & e);
		end
		// First own address match and receive role load a 0 over a 1
		pulse(4);
		pulse(8);
		amsec <= 0;
		rtx <= 0;
		pulse(4);
		pulse(8);
		apb(0, SSC_OFS_STAT2, 0, 4'hF);
		chk("first_addr_rx_role", 0, rd & 32'h84);
		csen <= 1;
		csv <= 8'($random(seed));
		apb(0, SSC_OFS_STAT2, 0, 4'hF);
		chk("checksum", {16'h0, csv, 8'h0}, rd & 32'hFF00);
		csen <= 0;
		apb(0, SSC_OFS_STAT2, 0, 4'hF);
		chk("checksum_off", 0, rd & 32'hFF00);
		$display("test status done");
		apb(1, SSC_OFS_FRAME, 32'h3, 4'h3);
		@(posedge pclk);
		chk("frame_ctl", 2'b11, {toen, fen});
		for (k = 0; k < 4; k++) begin
			if (k < 2)
				lvl[1] <= k == 0;
			else
				lvl[0] <= k == 2;
			repeat (6) @(posedge pclk);
			chk("irq_masked", 0, irq);
			apb(0, SSC_OFS_FRAME, 0, 4'hF);
			chk("frame_flags", fexp(k) | 3, rd & 32'hF303);
			// Only the enable that matches this flag is set
			apb(1, SSC_OFS_FRAME, 32'hF003 | (32'h80 >> k), 4'h3);
			repeat (2) @(posedge pclk);
			chk("irq_on", 1, irq);
			apb(1, SSC_OFS_FRAME, 32'h0003 | (32'h80 >> k), 4'h3);
			repeat (2) @(posedge pclk);
			chk("irq_cleared", 0, irq);
			apb(1, SSC_OFS_FRAME, 32'h3, 4'h3);
		end
		$display("test frame done");
		test_done();
	end
endmodule
bind ssc_regs ssc_regs_chk #(.DIV_W(DIV_W)) chk_i (.pclk, .presetn, .psel,
	.penable, .pwrite, .pready, .pslverr, .paddr, .pwdata, .prdata, .pstrb,
	.stop_seen, .fast_plus_enable, .clock_run, .scl_drive_low,
	.frame_timeout_enable, .frame_iface_enable, .rise_limit_field);
